// ---- pkg/tsr_defines.svh ----
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
// ----------------------------------------
// Pointer codes
// ----------------------------------------
`define TSR_PTR_MEAS      2'h0
`define TSR_PTR_SETTINGS  2'h1
`define TSR_PTR_LOWER     2'h2
`define TSR_PTR_UPPER     2'h3
// ----------------------------------------
// Power-up values
// ----------------------------------------
`define TSR_PTR_RST       2'h0
`define TSR_MEAS_RST      16'h0000
`define TSR_SETTINGS_RST  8'h00
`define TSR_LOWER_RST     16'h4b00
`define TSR_UPPER_RST     16'h5000
// ----------------------------------------
// Settings field positions
// ----------------------------------------
`define TSR_SET_PWRDN     0
`define TSR_SET_MODE      1
`define TSR_SET_POLARITY  2
`define TSR_SET_FAULT_LO  3
`define TSR_SET_FAULT_HI  4
`define TSR_SET_RSVD      7
// ----------------------------------------
// Link framing
// ----------------------------------------
`define TSR_ADDR_FIXED    4'h9
`define TSR_BIT_ACK       4'h8
`define TSR_BIT_DONE      4'h9
`define TSR_QTR_LAST      2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSR_CLK_MHZ       100
`define TSR_CONV_TIME_MS  150
`define TSR_CONV_CYC      (`TSR_CONV_TIME_MS * 1000 * `TSR_CLK_MHZ)
// ----------------------------------------
// Host register offsets and command fields
// ----------------------------------------
`define TSR_HREG_CMD      4'h0
`define TSR_HREG_WDATA    4'h4
`define TSR_HREG_RDATA    4'h8
`define TSR_HREG_STATUS   4'hc
`define TSR_CMD_READ      2
`define TSR_CMD_SETPTR    3
`endif

// ---- pkg/tsr_pkg.sv ----
// ----------------------------------------
// Shared types
// ----------------------------------------
package tsr_pkg;
	typedef logic [8:0] tsr_meas_t;  // Nine-bit two's complement reading
	typedef enum logic [2:0] {
		TSR_D_IDLE  = 3'b000,
		TSR_D_ADDR  = 3'b001,
		TSR_D_PTR   = 3'b010,
		TSR_D_WDATA = 3'b011,
		TSR_D_RDATA = 3'b100
	} tsr_dev_state_t;
	typedef enum logic [2:0] {
		TSR_H_IDLE  = 3'b000,
		TSR_H_START = 3'b001,
		TSR_H_BIT   = 3'b010,
		TSR_H_STOP  = 3'b011,
		TSR_H_GAP   = 3'b100
	} tsr_host_state_t;
	typedef enum logic [2:0] {
		TSR_S_ADDRW = 3'b000,
		TSR_S_PTR   = 3'b001,
		TSR_S_WR    = 3'b010,
		TSR_S_ADDRR = 3'b011,
		TSR_S_RD    = 3'b100
	} tsr_step_t;
endpackage

// ---- pkg/tsr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-wire link with open-drain resolution
// ----------------------------------------
interface tsr_link_if;
	logic scl;          // Serial clock, host drives
	logic host_sda_o;   // Host data level
	logic host_sda_oe;  // Host pulls data line
	logic dev_sda_o;    // Device data level
	logic dev_sda_oe;   // Device pulls data line
	logic alarm_o;      // Alarm level
	logic alarm_oe;     // Alarm pin pulled
	logic sda;          // Resolved data line, pulled up
	logic alarm;        // Resolved alarm line, pulled up
	assign sda   = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	assign alarm = !(alarm_oe && !alarm_o);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
		output alarm_o, output alarm_oe);
	modport host (output scl, output host_sda_o, output host_sda_oe,
		input sda, input alarm);
endinterface
`default_nettype wire

// ---- rtl/tsr_device.sv ----
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_device (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Serial link
	tsr_link_if.dev                link,
	// Address straps
	input  wire logic [2:0]        addr_strap_i,
	// Conversion engine
	input  wire logic              conv_done_i,
	input  wire tsr_pkg::tsr_meas_t conv_result_i,
	// Alarm comparator
	input  wire logic              alarm_active_i,
	// Settings to the engine
	output logic                   power_down_request_o,
	output logic                   alarm_mode_o,
	output logic                   alarm_polarity_o,
	output logic [1:0]             fault_count_sel_o,
	// Comparator operands
	output tsr_pkg::tsr_meas_t     cmp_meas_o,
	output tsr_pkg::tsr_meas_t     upper_trip_o,
	output tsr_pkg::tsr_meas_t     lower_trip_o,
	// Register read seen
	output logic                   reg_read_o
);
	import tsr_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0]     scl_sy;      // [0] first stage, [2] previous sample
	logic [2:0]     sda_sy;      // Same layout as the clock chain
	logic [2:0]     strap_s1;    // Strap first stage
	logic [2:0]     strap_s2;    // Strap second stage

	// Pins come from another domain, so two stages before any use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sy   <= 3'h7;
			sda_sy   <= 3'h7;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
		end else begin
			scl_sy   <= {scl_sy[1:0], link.scl};
			sda_sy   <= {sda_sy[1:0], link.sda};
			strap_s1 <= addr_strap_i;
			strap_s2 <= strap_s1;
		end
	end

	// ----------------------------------------
	// Bus conditions
	// ----------------------------------------
	logic           scl_rise;    // Clock went high
	logic           scl_fall;    // Clock went low
	logic           bus_start;   // Data falls with clock high
	logic           bus_stop;    // Data rises with clock high
	assign scl_rise  = scl_sy[1] && !scl_sy[2];
	assign scl_fall  = !scl_sy[1] && scl_sy[2];
	assign bus_start = scl_sy[1] && scl_sy[2] && sda_sy[2] && !sda_sy[1];
	assign bus_stop  = scl_sy[1] && scl_sy[2] && !sda_sy[2] && sda_sy[1];

	// ----------------------------------------
	// Protocol state
	// ----------------------------------------
	tsr_dev_state_t st;          // Transfer phase
	logic [3:0]     bit_cnt;     // Bits seen in current unit
	logic [7:0]     shreg;       // Received byte
	logic           byte_idx;    // 0 high byte, 1 low byte
	logic           ack_own;     // We drive this acknowledge
	logic [1:0]     ptr;         // Register select pointer
	logic [7:0]     tx_byte;     // Byte being sent
	logic           wr_now;      // Data byte complete in write
	logic           read_busy;   // Read transfer under way

	// Registers
	logic [15:0]    meas;        // Readable measurement
	logic [7:0]     settings;    // Settings byte
	logic [15:0]    lower_trip;  // Lower trip point
	logic [15:0]    upper_trip;  // Upper trip point
	tsr_meas_t      cmp_meas;    // Comparator buffer

	assign read_busy = (st == TSR_D_RDATA);
	assign wr_now    = scl_fall && !bus_start && !bus_stop
		&& (st == TSR_D_WDATA) && (bit_cnt == `TSR_BIT_ACK);

	// Selected byte, high byte first; settings is one byte
	always_comb begin
		case (ptr)
			`TSR_PTR_MEAS:     tx_byte = byte_idx ? meas[7:0] : meas[15:8];
			`TSR_PTR_SETTINGS: tx_byte = settings;
			`TSR_PTR_LOWER:    tx_byte = byte_idx ? lower_trip[7:0] : lower_trip[15:8];
			default:           tx_byte = byte_idx ? upper_trip[7:0] : upper_trip[15:8];
		endcase
	end

	// Slave engine; no conversion or alarm term gates it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st              <= TSR_D_IDLE;
			bit_cnt         <= 4'h0;
			shreg           <= 8'h00;
			byte_idx        <= 1'b0;
			ack_own         <= 1'b0;
			ptr             <= `TSR_PTR_RST;
			link.dev_sda_oe <= 1'b0;
		end else if (bus_start) begin
			// Pointer untouched, so a later read reuses it
			st              <= TSR_D_ADDR;
			bit_cnt         <= 4'h0;
			link.dev_sda_oe <= 1'b0;
		end else if (bus_stop) begin
			st              <= TSR_D_IDLE;
			link.dev_sda_oe <= 1'b0;
		end else if (st != TSR_D_IDLE && scl_rise) begin
			if (bit_cnt < `TSR_BIT_ACK) begin
				// Data bit sampled while clock high
				shreg   <= {shreg[6:0], sda_sy[1]};
				bit_cnt <= bit_cnt + 4'h1;
			end else begin
				bit_cnt <= `TSR_BIT_DONE;
				// Master refusal ends the read
				if (read_busy && !ack_own && sda_sy[1]) begin
					st <= TSR_D_IDLE;
				end
			end
		end else if (st != TSR_D_IDLE && scl_fall) begin
			if (bit_cnt == `TSR_BIT_ACK) begin
				ack_own         <= 1'b1;
				link.dev_sda_oe <= 1'b1;
				case (st)
					TSR_D_ADDR: begin
						// Match fixed part and strapped part
						if (shreg[7:1] == {`TSR_ADDR_FIXED, strap_s2}) begin
							st       <= shreg[0] ? TSR_D_RDATA : TSR_D_PTR;
							byte_idx <= 1'b0;
						end else begin
							st              <= TSR_D_IDLE;
							ack_own         <= 1'b0;
							link.dev_sda_oe <= 1'b0;
						end
					end
					TSR_D_PTR: begin
						// Stray high bits drop the transfer unacknowledged
						if (shreg[7:2] != 6'h00) begin
							st              <= TSR_D_IDLE;
							ack_own         <= 1'b0;
							link.dev_sda_oe <= 1'b0;
						end else begin
							ptr      <= shreg[1:0];
							st       <= TSR_D_WDATA;
							byte_idx <= 1'b0;
						end
					end
					TSR_D_WDATA: begin
						byte_idx <= 1'b1;
					end
					TSR_D_RDATA: begin
						// Release so the master can answer
						ack_own         <= 1'b0;
						link.dev_sda_oe <= 1'b0;
						byte_idx        <= 1'b1;
					end
					default: begin
						st <= TSR_D_IDLE;
					end
				endcase
			end else if (bit_cnt == `TSR_BIT_DONE) begin
				// Unit over: drop acknowledge, present next MSB
				bit_cnt         <= 4'h0;
				ack_own         <= 1'b0;
				link.dev_sda_oe <= read_busy && !tx_byte[7];
			end else if (read_busy && bit_cnt != 4'h0) begin
				link.dev_sda_oe <= !tx_byte[3'h7 - bit_cnt[2:0]];
			end
		end
	end

	// Open-drain data only ever pulls low
	always_ff @(posedge clk_i) begin
		link.dev_sda_o <= 1'b0;
	end

	// Pulse when a read is addressed, for alarm clearing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_read_o <= 1'b0;
		end else begin
			reg_read_o <= scl_fall && !bus_start && !bus_stop && st == TSR_D_ADDR
				&& bit_cnt == `TSR_BIT_ACK && shreg[0]
				&& shreg[7:1] == {`TSR_ADDR_FIXED, strap_s2};
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// A write to the reading register falls through untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settings   <= `TSR_SETTINGS_RST;
			lower_trip <= `TSR_LOWER_RST;
			upper_trip <= `TSR_UPPER_RST;
		end else if (wr_now) begin
			case (ptr)
				`TSR_PTR_SETTINGS: begin
					// Reserved bit keeps its value
					if (!byte_idx) begin
						settings <= {settings[`TSR_SET_RSVD], shreg[6:0]};
					end
				end
				`TSR_PTR_LOWER: begin
					if (byte_idx) lower_trip[7:0]  <= shreg;
					else          lower_trip[15:8] <= shreg;
				end
				`TSR_PTR_UPPER: begin
					if (byte_idx) upper_trip[7:0]  <= shreg;
					else          upper_trip[15:8] <= shreg;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Measurement capture
	// ----------------------------------------
	// A read in progress keeps the old value; the comparator still sees new
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meas     <= `TSR_MEAS_RST;
			cmp_meas <= 9'h000;
		end else if (conv_done_i) begin
			cmp_meas <= conv_result_i;
			if (!read_busy) begin
				meas <= {conv_result_i, 7'h00};
			end
		end
	end

	// ----------------------------------------
	// Alarm pin
	// ----------------------------------------
	// Pull low when the pin level must be low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.alarm_oe <= 1'b0;
		end else begin
			link.alarm_oe <= alarm_active_i ^ settings[`TSR_SET_POLARITY];
		end
	end

	always_ff @(posedge clk_i) begin
		link.alarm_o <= 1'b0;
	end

	// ----------------------------------------
	// Outputs to engine and comparator
	// ----------------------------------------
	assign power_down_request_o = settings[`TSR_SET_PWRDN];
	assign alarm_mode_o         = settings[`TSR_SET_MODE];
	assign alarm_polarity_o     = settings[`TSR_SET_POLARITY];
	assign fault_count_sel_o    = settings[`TSR_SET_FAULT_HI:`TSR_SET_FAULT_LO];
	assign cmp_meas_o           = cmp_meas;
	assign upper_trip_o         = upper_trip[15:7];
	assign lower_trip_o         = lower_trip[15:7];
endmodule
`default_nettype wire

// ---- rtl/tsr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_host #(
	parameter int unsigned GAP_CYCLES = `TSR_CONV_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Serial link
	tsr_link_if.host         link
);
	import tsr_pkg::*;

	// ----------------------------------------
	// Synchronisers and registers
	// ----------------------------------------
	logic [1:0]      sda_sy;     // Data line, two stages
	logic [1:0]      alarm_sy;   // Alarm line, two stages
	tsr_host_state_t st;         // Sequencer state
	tsr_step_t       step;       // Which byte is on the wire
	logic [1:0]      sub;        // Cycle within a quarter
	logic [1:0]      qtr;        // Quarter within a bit
	logic [3:0]      bitn;       // Bit within a unit
	logic [7:0]      rxb;        // Received byte
	logic            bcnt;       // Data byte index
	logic [23:0]     gap_cnt;    // Spacing counter
	logic [1:0]      cmd_ptr;    // Target register
	logic            cmd_rd;     // Read operation
	logic            cmd_setptr; // Send pointer before read
	logic [2:0]      cmd_addr;   // Strap part of address
	logic [15:0]     wdata;      // Data to write
	logic [15:0]     rdata;      // Data read back
	logic            nack;       // Device refused a byte
	logic            bus_req;    // Request at the acking edge
	logic            cmd_go;     // Accepted command
	logic            tick;       // End of a quarter
	logic            sending;    // Host transmits this byte
	logic            two;        // Wide register
	logic            last;       // Final data byte
	logic [7:0]      txb;        // Byte to send

	assign bus_req = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign cmd_go  = bus_req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == `TSR_HREG_CMD && st == TSR_H_IDLE;
	assign tick    = (sub == `TSR_QTR_LAST);
	assign sending = (step != TSR_S_RD);
	assign two     = (cmd_ptr != `TSR_PTR_SETTINGS);
	assign last    = !two || bcnt;

	// Pointer byte keeps its upper six bits clear
	always_comb begin
		case (step)
			TSR_S_ADDRW: txb = {`TSR_ADDR_FIXED, cmd_addr, 1'b0};
			TSR_S_PTR:   txb = {6'h00, cmd_ptr};
			TSR_S_WR:    txb = (two && !bcnt) ? wdata[15:8] : wdata[7:0];
			TSR_S_ADDRR: txb = {`TSR_ADDR_FIXED, cmd_addr, 1'b1};
			default:     txb = 8'hff;
		endcase
	end

	// Pin inputs cross into this clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_sy   <= 2'h3;
			alarm_sy <= 2'h3;
		end else begin
			sda_sy   <= {sda_sy[0], link.sda};
			alarm_sy <= {alarm_sy[0], link.alarm};
		end
	end

	// ----------------------------------------
	// Wishbone slave, one wait state
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0;
			wdata      <= 16'h0000;
			cmd_ptr    <= 2'h0;
			cmd_rd     <= 1'b0;
			cmd_setptr <= 1'b0;
			cmd_addr   <= 3'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			case (wb_adr_i)
				`TSR_HREG_RDATA:  wb_dat_o <= {16'h0000, rdata};
				`TSR_HREG_STATUS: wb_dat_o <= {29'h0, alarm_sy[1], nack, st != TSR_H_IDLE};
				`TSR_HREG_CMD:    wb_dat_o <= {25'h0, cmd_addr, cmd_setptr, cmd_rd, cmd_ptr};
				`TSR_HREG_WDATA:  wb_dat_o <= {16'h0000, wdata};
				default:          wb_dat_o <= 32'h0;
			endcase
			if (bus_req && wb_we_i && wb_adr_i == `TSR_HREG_WDATA) begin
				if (wb_sel_i[0]) wdata[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) wdata[15:8] <= wb_dat_i[15:8];
			end
			if (cmd_go) begin
				cmd_ptr    <= wb_dat_i[1:0];
				cmd_rd     <= wb_dat_i[`TSR_CMD_READ];
				cmd_setptr <= wb_dat_i[`TSR_CMD_SETPTR];
				cmd_addr   <= wb_dat_i[6:4];
			end
		end
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	// Writes always carry a pointer; reads may reuse the held one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st               <= TSR_H_IDLE;
			step             <= TSR_S_ADDRW;
			sub              <= 2'h0;
			qtr              <= 2'h0;
			bitn             <= 4'h0;
			rxb              <= 8'h00;
			bcnt             <= 1'b0;
			gap_cnt          <= 24'h0;
			rdata            <= 16'h0000;
			nack             <= 1'b0;
			link.scl         <= 1'b1;
			link.host_sda_oe <= 1'b0;
		end else if (st == TSR_H_IDLE) begin
			if (cmd_go) begin
				st   <= TSR_H_START;
				step <= (wb_dat_i[`TSR_CMD_READ] && !wb_dat_i[`TSR_CMD_SETPTR])
					? TSR_S_ADDRR : TSR_S_ADDRW;
				sub  <= 2'h0;
				qtr  <= 2'h0;
				bcnt <= 1'b0;
				nack <= 1'b0;
			end
		end else if (st == TSR_H_GAP) begin
			// Spacing lets the device reload its reading
			gap_cnt <= gap_cnt + 24'h1;
			if (gap_cnt >= 24'(GAP_CYCLES - 1)) begin
				st      <= TSR_H_IDLE;
				gap_cnt <= 24'h0;
			end
		end else begin
			sub <= sub + 2'h1;
			if (tick) begin
				qtr <= qtr + 2'h1;
				case (st)
					TSR_H_START: begin
						if (qtr == 2'h0) link.host_sda_oe <= 1'b0;
						if (qtr == 2'h1) link.scl <= 1'b1;
						if (qtr == 2'h2) link.host_sda_oe <= 1'b1;
						if (qtr == 2'h3) begin
							link.scl <= 1'b0;
							st       <= TSR_H_BIT;
							bitn     <= 4'h0;
						end
					end
					TSR_H_BIT: begin
						if (qtr == 2'h0) begin
							if (bitn == `TSR_BIT_ACK)
								link.host_sda_oe <= !sending && !last;
							else
								link.host_sda_oe <= sending && !txb[3'h7 - bitn[2:0]];
						end
						if (qtr == 2'h1) link.scl <= 1'b1;
						if (qtr == 2'h3) begin
							link.scl <= 1'b0;
							bitn     <= bitn + 4'h1;
							if (bitn < `TSR_BIT_ACK) begin
								rxb <= {rxb[6:0], sda_sy[1]};
							end else if (sending && sda_sy[1]) begin
								nack <= 1'b1;
								st   <= TSR_H_STOP;
							end else begin
								// Nine clocks per unit, none idle
								bitn <= 4'h0;
								case (step)
									TSR_S_ADDRW: step <= TSR_S_PTR;
									TSR_S_PTR: begin
										if (cmd_rd) begin
											step <= TSR_S_ADDRR;
											st   <= TSR_H_START;
										end else begin
											step <= TSR_S_WR;
										end
									end
									TSR_S_ADDRR: step <= TSR_S_RD;
									TSR_S_RD: begin
										if (two && !bcnt) rdata[15:8] <= rxb;
										else              rdata[7:0]  <= rxb;
										if (last) st <= TSR_H_STOP;
										bcnt <= 1'b1;
									end
									default: begin
										if (last) st <= TSR_H_STOP;
										bcnt <= 1'b1;
									end
								endcase
							end
						end
					end
					TSR_H_STOP: begin
						if (qtr == 2'h0) link.host_sda_oe <= 1'b1;
						if (qtr == 2'h1) link.scl <= 1'b1;
						if (qtr == 2'h2) link.host_sda_oe <= 1'b0;
						if (qtr == 2'h3) st <= TSR_H_GAP;
					end
					default: st <= TSR_H_IDLE;
				endcase
			end
		end
	end

	// Open-drain data only ever pulls low
	always_ff @(posedge clk_i) begin
		link.host_sda_o <= 1'b0;
	end
endmodule
`default_nettype wire

// ---- testbench/tsr_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsr_monitor (
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// Link wires and enables
	input wire logic	scl,
	input wire logic	sda,
	input wire logic	host_sda_o,
	input wire logic	host_sda_oe,
	input wire logic	dev_sda_o,
	input wire logic	dev_sda_oe,
	input wire logic	alarm_o,
	input wire logic	alarm_oe
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------
	// Bus conditions
	// ------------
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	// Frame flag; start sets it, stop clears it
	logic	in_frame;
	always_ff @(posedge clk_i) begin
		if (rst_i || (scl && $past(scl) && $rose(sda))) begin
			in_frame <= 1'b0;
		end else if (scl && $past(scl) && $fell(sda)) begin
			in_frame <= 1'b1;
		end
	end
	// ------------
	// Properties
	// ------------
	// Host holds its data level for four cycles after the clock rises; pins only pull low
	property p_host_od;
		$rose(scl) |-> ($stable(host_sda_oe) && !host_sda_o)[*4];
	endproperty
	a_host_od: assert property (p_host_od) else $error("host moved data with clock high");
	// Device reacts three cycles after the clock falls, synchroniser delay
	property p_dev_od;
		$changed(dev_sda_oe) |-> !scl && $past(scl, 4) && !dev_sda_o;
	endproperty
	a_dev_od: assert property (p_dev_od) else $error("device moved data off clock fall");
	property p_alarm_od;
		alarm_oe |-> !alarm_o;
	endproperty
	a_alarm_od: assert property (p_alarm_od) else $error("alarm pin driven high");
	// Device may only move data while the clock is low
	property p_dev_stable;
		scl && $past(scl) |-> $stable(dev_sda_oe);
	endproperty
	a_dev_stable: assert property (p_dev_stable) else $error("device moved data");
	property p_scl_low;
		$fell(scl) |-> ##[1:20] scl;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock held low");
	property p_start_clk;
		s_start |-> ##[1:20] !scl;
	endproperty
	a_start_clk: assert property (p_start_clk) else $error("no clock after start");
	property p_dev_quiet;
		!in_frame |-> !dev_sda_oe;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet) else $error("device pulls outside frame");
	property p_stop_idle;
		s_stop |=> (scl && sda)[*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
endmodule
`default_nettype wire

// ---- testbench/tsr_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_tb;
	import tsr_pkg::*;
	// ------------
	// Signals
	// ------------
	logic	clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]	wb_adr_i, wb_sel_i;
	logic [31:0]	wb_dat_i, wb_dat_o, q;
	logic [2:0]	addr_strap_i;
	logic	conv_done_i, alarm_active_i, reg_read_o;
	tsr_meas_t	conv_result_i, cmp_meas_o, upper_trip_o, lower_trip_o;
	logic	power_down_request_o, alarm_mode_o, alarm_polarity_o;
	logic [1:0]	fault_count_sel_o;
	int	err_count, comparisons, n;
	logic [15:0]	pwr_up [4] = '{16'h0000, 16'h0000, 16'h4b00, 16'h5000};
	// ------------
	// Both ends joined on one link
	// ------------
	tsr_link_if i_tsr_link_if ();
	tsr_host #(.GAP_CYCLES(20)) i_tsr_host (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(i_tsr_link_if));
	tsr_device i_tsr_device (.clk_i, .rst_i, .link(i_tsr_link_if), .addr_strap_i, .conv_done_i,
		.conv_result_i, .alarm_active_i, .power_down_request_o, .alarm_mode_o, .alarm_polarity_o,
		.fault_count_sel_o, .cmp_meas_o, .upper_trip_o, .lower_trip_o, .reg_read_o);
	tsr_monitor i_tsr_monitor (.clk_i, .rst_i, .scl(i_tsr_link_if.scl), .sda(i_tsr_link_if.sda),
		.host_sda_o(i_tsr_link_if.host_sda_o), .host_sda_oe(i_tsr_link_if.host_sda_oe),
		.dev_sda_o(i_tsr_link_if.dev_sda_o), .dev_sda_oe(i_tsr_link_if.dev_sda_oe),
		.alarm_o(i_tsr_link_if.alarm_o), .alarm_oe(i_tsr_link_if.alarm_oe));
	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ------------
	// Tasks
	// ------------
	task automatic test_done;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// A wait ran out of bound
	task automatic give_up;
		err_count++;
		test_done;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Classic cycle; request held until ack, data taken at that edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) give_up;
	endtask
	// Poll busy until the link transfer and its gap are over
	task automatic idle;
		for (int i = 0; i <= 3000; i++) begin
			wb(1'b0, `TSR_HREG_STATUS, 32'h0);
			if (q[0] === 1'b0) break;
			if (i == 3000) give_up;
		end
	endtask
	task automatic xfer(input logic [2:0] st, input logic s, input logic r, input logic [1:0] p);
		wb(1'b1, `TSR_HREG_CMD, {25'h0, st, s, r, p});
		idle;
	endtask
	// Settings is one byte wide, so only its low byte counts
	task automatic rd(input logic [1:0] p, input logic s, input logic [15:0] e);
		xfer(3'h5, s, 1'b1, p);
		wb(1'b0, `TSR_HREG_RDATA, 32'h0);
		chk("register read", 32'(e), 32'(q[15:0] & ((s && p == 2'h1) ? 16'h00ff : 16'hffff)));
	endtask
	task automatic wr(input logic [1:0] p, input logic [15:0] v);
		wb(1'b1, `TSR_HREG_WDATA, 32'(v));
		xfer(3'h5, 1'b1, 1'b0, p);
	endtask
	task automatic conv(input tsr_meas_t r);
		@(posedge clk_i);
		conv_done_i <= 1'b1;
		conv_result_i <= r;
		@(posedge clk_i);
		conv_done_i <= 1'b0;
	endtask
	// ------------
	// Main sequence
	// ------------
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		addr_strap_i = 3'h5;
		{conv_done_i, conv_result_i, alarm_active_i} = '0;
		err_count = 0;
		comparisons = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		// Power-up contents behind every pointer code
		for (int i = 0; i < 4; i++) begin
			rd(2'(i), 1'b1, pwr_up[i]);
		end
		rd(2'h0, 1'b0, 16'h5000);
		chk("upper trip", 32'h0a0, 32'(upper_trip_o));
		chk("lower trip", 32'h096, 32'(lower_trip_o));
		chk("settings out", 32'h0, 32'({fault_count_sel_o, alarm_polarity_o, alarm_mode_o}));
		$display("test power-up done");
		// Reading lands in 15..7; writes to it are dropped
		conv(9'h1ce);
		rd(2'h0, 1'b1, 16'he700);
		wr(2'h0, 16'hffff);
		rd(2'h0, 1'b1, 16'he700);
		$display("test reading done");
		// Alarm level, inverted then default polarity; every field set once
		alarm_active_i <= 1'b1;
		wr(2'h1, 16'h009f);
		rd(2'h1, 1'b1, 16'h001f);
		chk("settings out", 32'h1f, 32'({fault_count_sel_o, alarm_polarity_o, alarm_mode_o,
			power_down_request_o}));
		wb(1'b0, `TSR_HREG_STATUS, 32'h0);
		chk("alarm pin", 32'h1, 32'(q[2]));
		wr(2'h1, 16'h0000);
		wb(1'b0, `TSR_HREG_STATUS, 32'h0);
		chk("alarm pin", 32'h0, 32'(q[2]));
		wr(2'h3, 16'h12ff);
		rd(2'h3, 1'b1, 16'h12ff);
		chk("upper trip", 32'h025, 32'(upper_trip_o));
		wr(2'h2, 16'h1b80);
		rd(2'h2, 1'b1, 16'h1b80);
		chk("lower trip", 32'h037, 32'(lower_trip_o));
		$display("test settings done");
		// Foreign strap address gets no acknowledge
		xfer(3'h2, 1'b1, 1'b1, 2'h0);
		wb(1'b0, `TSR_HREG_STATUS, 32'h0);
		chk("refused", 32'h1, 32'(q[1]));
		$display("test address done");
		// Conversion landing inside a read is not loaded
		wb(1'b1, `TSR_HREG_CMD, {25'h0, 3'h5, 1'b1, 1'b1, 2'h0});
		for (n = 0; reg_read_o !== 1'b1 && n < 3000; n++) @(posedge clk_i);
		if (n == 3000) give_up;
		conv(9'h032);
		idle;
		wb(1'b0, `TSR_HREG_RDATA, 32'h0);
		chk("read during update", 32'he700, 32'(q[15:0]));
		chk("compare value", 32'h032, 32'(cmp_meas_o));
		rd(2'h0, 1'b0, 16'he700);
		conv(9'h032);
		rd(2'h0, 1'b0, 16'h1900);
		$display("test read lock done");
		test_done;
	end
endmodule
`default_nettype wire
